// ---- include/mslrs_pkg.sv ----
package mslrs_pkg;

	// Clock rate and timing base.
	localparam int unsigned CLK_HZ       = 25_000_000;
	localparam int unsigned TICK_US      = 1000;
	localparam int unsigned TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned TICK_W       = 15;

	// Widths of settings and measurements.
	localparam int unsigned CUR_W        = 16;
	localparam int unsigned TIME_W       = 20;
	localparam int unsigned ACC_W        = 52;

	// Reset values.
	localparam logic [TIME_W-1:0] TIME_RST = 20'h0_0000;
	localparam logic [ACC_W-1:0]  ACC_RST  = 52'h0_0000_0000_0000;

	// Operating principle selection encoding.
	localparam logic MODE_DEF_TIME = 1'b0;
	localparam logic MODE_I2T      = 1'b1;

	typedef enum logic [3:0] {
		MSLRS_STOPPED  = 4'b0001,
		MSLRS_STARTING = 4'b0010,
		MSLRS_RUNNING  = 4'b0100,
		MSLRS_STALLED  = 4'b1000
	} mslrs_state_t;

endpackage

// ---- hdl/mslrs_supervisor.sv ----
// What this block does
// - Supervision runs either as a fixed time limit or as a current-squared-time limit.
// - In current-squared-time mode a lower start current is allowed a longer start.
// - The time limit is the manual setting or the hot or cold stall time picked by thermal status.
// - The allowed start time and the use of the speed switch are separate settings.
// - In current-squared-time mode the sum is compared with its limit during a start, no trip below it.
// - A start beyond the allowed limit without speed-switch extension trips the breaker.
// - With the speed switch in use and reporting rotation the start may run past the limit.
// - After the start the block can supervise the running motor for a stall.
// - A start begins on current above start-detect from stopped and ends below max overload.
// - A stall uses the same limits as a start and trips when it lasts beyond them.
`timescale 1ns/1ps

module mslrs_supervisor
	import mslrs_pkg::*;
(
	input  wire logic                               core_clk,
	input  wire logic                               rst,
	input  wire logic [mslrs_pkg::CUR_W-1:0]        phase_current,
	input  wire logic [mslrs_pkg::CUR_W-1:0]        no_load_level,
	input  wire logic [mslrs_pkg::CUR_W-1:0]        start_detect_level,
	input  wire logic [mslrs_pkg::CUR_W-1:0]        max_overload_level,
	input  wire logic [mslrs_pkg::CUR_W-1:0]        nom_start_current,
	input  wire logic                               i2t_mode_sel,
	input  wire logic                               auto_stall_time_sel,
	input  wire logic [mslrs_pkg::TIME_W-1:0]       manual_start_time,
	input  wire logic [mslrs_pkg::TIME_W-1:0]       hot_stall_time,
	input  wire logic [mslrs_pkg::TIME_W-1:0]       cold_stall_time,
	input  wire logic                               thermal_hot,
	input  wire logic                               speed_switch_en,
	input  wire logic                               speed_switch_pin,
	input  wire logic                               stall_mon_en,
	output logic                                    breaker_trip,
	output logic                                    motor_starting,
	output logic                                    motor_stalled
);
	import mslrs_pkg::*;

	mslrs_state_t          state_r;
	mslrs_state_t          state_nxt;
	logic [TICK_W-1:0]     tick_cnt_r;
	logic                  tick;
	logic [TIME_W-1:0]     elapsed_r;
	logic [ACC_W-1:0]      acc_r;
	logic [ACC_W-1:0]      acc_lim;
	logic [TIME_W-1:0]     time_lim;
	logic                  over_lim;
	logic [2:0]            spd_sync_r;
	logic                  spd_r;
	logic                  supervising;
	logic                  trip_r;

	function automatic logic [2*CUR_W-1:0] sq(input logic [CUR_W-1:0] v);
		sq = v * v;
	endfunction

	// Millisecond tick so the time settings are held in milliseconds.
	assign tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));

	always_ff @(posedge core_clk)
	begin
		if (rst || tick)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick_cnt_r + 1'b1;
	end

	// Speed switch is a pin; a change counts once two late stages agree.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			spd_sync_r <= 3'h0;
			spd_r      <= 1'b0;
		end
		else
		begin
			spd_sync_r <= {spd_sync_r[1:0], speed_switch_pin};
			if (spd_sync_r[1] == spd_sync_r[2])
				spd_r <= spd_sync_r[2];
		end
	end

	// Manual or thermal-status driven choice of the time limit.
	assign time_lim = auto_stall_time_sel ?
		(thermal_hot ? hot_stall_time : cold_stall_time) :
		manual_start_time;

	// The current-squared-time budget is nominal start current squared times
	// the allowed time, so a lower current takes longer by the square of the ratio.
	assign acc_lim = ACC_W'(sq(nom_start_current)) * ACC_W'(time_lim);

	always_comb
	begin
		if (i2t_mode_sel == MODE_I2T)
			over_lim = (acc_r > acc_lim);
		else
			over_lim = (elapsed_r > time_lim);
	end

	assign supervising = (state_r == MSLRS_STARTING) ||
		(state_r == MSLRS_STALLED);

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			MSLRS_STOPPED:
				if (phase_current > start_detect_level)
					state_nxt = MSLRS_STARTING;
			MSLRS_STARTING:
				if (phase_current < max_overload_level)
					state_nxt = MSLRS_RUNNING;
			MSLRS_RUNNING:
				if (phase_current < no_load_level)
					state_nxt = MSLRS_STOPPED;
				else if (stall_mon_en && phase_current > max_overload_level)
					state_nxt = MSLRS_STALLED;
			MSLRS_STALLED:
				if (phase_current < max_overload_level)
					state_nxt = MSLRS_RUNNING;
			default:
				state_nxt = MSLRS_STOPPED;
		endcase
		if (trip_r)
			state_nxt = MSLRS_STOPPED;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			state_r <= MSLRS_STOPPED;
		else
			state_r <= state_nxt;
	end

	// Time and current-squared-time sums, restarted at each start or stall.
	always_ff @(posedge core_clk)
	begin
		if (rst || !supervising)
		begin
			elapsed_r <= TIME_RST;
			acc_r     <= ACC_RST;
		end
		else if (tick)
		begin
			if (elapsed_r != {TIME_W{1'b1}})
				elapsed_r <= elapsed_r + 1'b1;
			if (acc_r < acc_lim + ACC_W'(1))
				acc_r <= acc_r + ACC_W'(sq(phase_current));
		end
	end

	// Trip holds until the current has gone away, so the breaker sees it.
	always_ff @(posedge core_clk)
	begin
		if (rst)
			trip_r <= 1'b0;
		else if (supervising && over_lim &&
			!(speed_switch_en && spd_r))
			trip_r <= 1'b1;
		else if (phase_current < no_load_level)
			trip_r <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			breaker_trip   <= 1'b0;
			motor_starting <= 1'b0;
			motor_stalled  <= 1'b0;
		end
		else
		begin
			breaker_trip   <= trip_r;
			motor_starting <= (state_r == MSLRS_STARTING);
			motor_stalled  <= (state_r == MSLRS_STALLED);
		end
	end

	trip_cause_a: assert property (
		@(posedge core_clk) disable iff (rst)
		$rose(trip_r) |-> $past(over_lim) && $past(supervising))
		else $error("trip without an exceeded limit");
	spd_hold_a: assert property (
		@(posedge core_clk) disable iff (rst)
		supervising && speed_switch_en && spd_r && !trip_r |=> !$rose(trip_r))
		else $error("trip despite speed switch");
	trip_out_a: assert property (
		@(posedge core_clk) disable iff (rst)
		$rose(trip_r) |=> breaker_trip)
		else $error("trip not passed to breaker");
	start_clear_a: assert property (
		@(posedge core_clk) disable iff (rst)
		$rose(supervising) |-> elapsed_r == TIME_RST && acc_r == ACC_RST)
		else $error("sums not cleared at start");
	start_detect_a: assert property (
		@(posedge core_clk) disable iff (rst)
		state_r == MSLRS_STOPPED && phase_current > start_detect_level
		&& !trip_r |=> state_r == MSLRS_STARTING)
		else $error("start not detected");
	start_end_a: assert property (
		@(posedge core_clk) disable iff (rst)
		state_r == MSLRS_STARTING && phase_current < max_overload_level
		&& !trip_r |=> state_r == MSLRS_RUNNING)
		else $error("start end not detected");
	start_trip_a: assert property (
		@(posedge core_clk) disable iff (rst)
		state_r == MSLRS_STARTING && over_lim
		&& !(speed_switch_en && spd_r) |=> trip_r)
		else $error("long start not tripped");
	stall_enter_a: assert property (
		@(posedge core_clk) disable iff (rst)
		state_r == MSLRS_STALLED && $past(state_r) == MSLRS_RUNNING
		|-> $past(stall_mon_en))
		else $error("stall without monitoring");
	// A stall restarts both sums, so it gets the full start limit again.
	stall_trip_a: assert property (
		@(posedge core_clk) disable iff (rst)
		state_r == MSLRS_STALLED && over_lim
		&& !(speed_switch_en && spd_r) |=> trip_r)
		else $error("long stall not tripped");
	def_time_a: assert property (
		@(posedge core_clk) disable iff (rst)
		i2t_mode_sel == MODE_DEF_TIME && supervising && !trip_r
		&& elapsed_r <= time_lim |=> !$rose(trip_r))
		else $error("early definite-time trip");
	i2t_within_a: assert property (
		@(posedge core_clk) disable iff (rst)
		i2t_mode_sel == MODE_I2T && !trip_r && acc_r <= acc_lim
		|=> !$rose(trip_r))
		else $error("trip inside the budget");
endmodule

// ---- testbench/mslrs_plant.sv ----
`timescale 1ns/1ps

module mslrs_plant
	import mslrs_pkg::*;
(
	input  wire logic                        core_clk,
	input  wire logic                        breaker_trip,
	input  wire logic                        close_cmd,
	input  wire logic [mslrs_pkg::CUR_W-1:0] demand,
	input  wire logic                        rotating,
	output logic      [mslrs_pkg::CUR_W-1:0] phase_current,
	output logic                             speed_switch_pin
);
	logic closed_r = 1'h0;

	// An opened breaker stays open while the trip is held.
	// It recloses only on the bench's command, so a stuck trip shows.
	always_ff @(posedge core_clk)
		closed_r <= breaker_trip ? 1'h0 : (close_cmd ? 1'h1 : closed_r);
	assign phase_current    = closed_r ? demand : 16'h0000;
	assign speed_switch_pin = rotating;
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
	import mslrs_pkg::*;
	logic              core_clk = 1'h0;
	logic              rst      = 1'h1;
	logic              close_cmd, rotating, i2t, auto_sel, hot, ss_en;
	logic              stall_en, trip, starting, stalled, ss_pin;
	logic [CUR_W-1:0]  demand, cur;
	logic [TIME_W-1:0] man_t, hot_t, cold_t;
	int                bad_count, checks;

	always #20 core_clk = ~core_clk;

	mslrs_plant plant (.core_clk(core_clk), .breaker_trip(trip),
		.close_cmd(close_cmd), .demand(demand), .rotating(rotating),
		.phase_current(cur), .speed_switch_pin(ss_pin));
	mslrs_supervisor DUT (.core_clk(core_clk), .rst(rst),
		.phase_current(cur), .no_load_level(16'h0010),
		.start_detect_level(16'h0100), .max_overload_level(16'h0080),
		.nom_start_current(16'h0200), .i2t_mode_sel(i2t),
		.auto_stall_time_sel(auto_sel), .manual_start_time(man_t),
		.hot_stall_time(hot_t), .cold_stall_time(cold_t),
		.thermal_hot(hot), .speed_switch_en(ss_en),
		.speed_switch_pin(ss_pin), .stall_mon_en(stall_en),
		.breaker_trip(trip), .motor_starting(starting),
		.motor_stalled(stalled));

	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask

	task automatic chk(string nm, logic e, logic s);
		checks++;
		if (s !== e)
		begin
			$display("[ERR] %s expected %b seen %b", nm, e, s);
			bad_count++;
		end
	endtask

	task automatic test_done;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Bounded wait; running out ends the run through the verdict.
	task automatic wait_trip(int n, logic lvl);
		int i;
		i = 0;
		while (trip !== lvl && i < n)
		begin
			tick(1);
			i++;
		end
		chk("breaker_trip", lvl, trip);
		if (trip !== lvl)
			test_done();
	endtask

	initial
	begin
		{close_cmd, rotating, i2t, auto_sel, hot, ss_en, stall_en} = '0;
		demand = 16'h0000;
		man_t  = 20'h0_1388;
		hot_t  = 20'h0_1388;
		cold_t = 20'h0_1388;
		tick(3);
		rst = 1'h0;
		chk("breaker_trip", 1'h0, trip);
		chk("motor_starting", 1'h0, starting);
		close_cmd = 1'h1;
		demand    = 16'h0200;
		tick(5);
		chk("motor_starting", 1'h1, starting);
		demand = 16'h0040;
		tick(3);
		chk("motor_starting", 1'h0, starting);
		demand = 16'h0000;
		tick(3);
		$display("test 1 done");
		// Zero limit, first from the manual setting, then the hot stall time.
		for (int k = 0; k < 2; k++)
		begin
			auto_sel = k[0];
			i2t      = k[0];
			hot      = k[0];
			man_t    = k[0] ? 20'h0_1388 : 20'h0_0000;
			hot_t    = k[0] ? 20'h0_0000 : 20'h0_1388;
			demand   = 16'h0200;
			wait_trip(30000, 1'h1);
			tick(1);
			chk("motor_starting", 1'h0, starting);
			wait_trip(10, 1'h0);
			demand = 16'h0000;
			tick(3);
			$display("test %0d done", k + 2);
		end
		// Cold stall time rules now; the hot one is long so a wrong pick shows.
		hot      = 1'h0;
		cold_t   = 20'h0_0000;
		hot_t    = 20'h0_1388;
		ss_en    = 1'h1;
		rotating = 1'h1;
		tick(5);
		demand   = 16'h0200;
		tick(30000);
		chk("breaker_trip", 1'h0, trip);
		chk("motor_starting", 1'h1, starting);
		rotating = 1'h0;
		wait_trip(20, 1'h1);
		wait_trip(10, 1'h0);
		$display("test 4 done");
		// The reclosed breaker starts the motor again, which then stalls.
		i2t = 1'h0;
		tick(4);
		chk("motor_starting", 1'h1, starting);
		demand = 16'h0040;
		tick(3);
		chk("motor_starting", 1'h0, starting);
		stall_en = 1'h1;
		demand   = 16'h0200;
		tick(3);
		chk("motor_stalled", 1'h1, stalled);
		chk("motor_starting", 1'h0, starting);
		wait_trip(30000, 1'h1);
		tick(1);
		chk("motor_stalled", 1'h0, stalled);
		$display("test 5 done");
		test_done();
	end
endmodule
